// file: rtl/dpram_map.svh
// Constants for the dual-port synchronous RAM core
`ifndef DPRAM_MAP_SVH
`define DPRAM_MAP_SVH
`define DPRAM_ADDR_W_64K 16
`define DPRAM_ADDR_W_128K 17
`define DPRAM_ADDR_W_256K 18
`define DPRAM_DATA_W 72
`define DPRAM_BYTE_W 8
`define DPRAM_LANES 9
`define DPRAM_BURST_STEP 1
`endif

// file: rtl/dpram_pkg.sv
// Types shared by the dual-port RAM core
`include "dpram_map.svh"
package dpram_pkg;
  typedef logic [`DPRAM_DATA_W-1:0] dpram_word_t;
  typedef logic [`DPRAM_LANES-1:0] dpram_lanes_t;
  // One port's request as seen on its pins
  typedef struct packed {
    logic chip_enable_active_low;
    logic chip_enable_active_high;
    logic addr_load;
    logic addr_advance;
    logic write_sel;
    logic [`DPRAM_ADDR_W_256K-1:0] addr;
    dpram_lanes_t byte_en;
    dpram_word_t wdata;
  } dpram_req_t;
  // One port's answer
  typedef struct packed {
    dpram_word_t rdata;
    logic rvalid;
    logic out_en;
  } dpram_rsp_t;
  typedef enum logic [1:0] {
    DPRAM_ST_DOWN = 2'b01,
    DPRAM_ST_ACTIVE = 2'b10
  } dpram_state_t;
endpackage : dpram_pkg

// file: rtl/dpram_rst_sync.sv
// Reset release synchroniser
`timescale 1ns/1ps
module dpram_rst_sync (
  // Clock and raw reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Synchronised reset
  output logic rst_sync_n
);
  logic meta_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      rst_sync_n <= meta_q;
    end
  end
endmodule : dpram_rst_sync

// file: rtl/dpram_port.sv
// One port front end: input registers, burst counter, power state
`timescale 1ns/1ps
`include "dpram_map.svh"
module dpram_port #(
  parameter int ADDR_W = `DPRAM_ADDR_W_64K
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Pin side
  input wire dpram_pkg::dpram_req_t req,
  // Array side, registered
  output logic enabled_q,
  output logic wr_q,
  output logic rd_q,
  output logic [ADDR_W-1:0] addr_q,
  output dpram_pkg::dpram_lanes_t be_q,
  output dpram_pkg::dpram_word_t wdata_q
);
  import dpram_pkg::*;
  dpram_state_t state_q;
  logic [ADDR_W-1:0] cnt_q;
  wire sel = !req.chip_enable_active_low && req.chip_enable_active_high;
  wire [ADDR_W-1:0] pin_addr = req.addr[ADDR_W-1:0];
  wire [ADDR_W-1:0] cnt_next = cnt_q + ADDR_W'(`DPRAM_BURST_STEP);
  wire [ADDR_W-1:0] addr_d = req.addr_load ? pin_addr :
                             (req.addr_advance ? cnt_next : cnt_q);
  wire dpram_state_t state_d = sel ? DPRAM_ST_ACTIVE : DPRAM_ST_DOWN;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DPRAM_ST_DOWN;
      cnt_q <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      be_q <= '0;
      wdata_q <= '0;
    end else begin
      state_q <= state_d;
      if (sel) begin
        cnt_q <= addr_d;
      end
      wr_q <= sel && req.write_sel;
      rd_q <= sel && !req.write_sel;
      be_q <= req.byte_en;
      wdata_q <= req.wdata;
    end
  end
  assign addr_q = cnt_q;
  assign enabled_q = (state_q == DPRAM_ST_ACTIVE);
endmodule : dpram_port

// file: rtl/dpram_core.sv
// Two-port synchronous pipelined RAM core with 72-bit words
`timescale 1ns/1ps
`include "dpram_map.svh"
// Behaviour
// - Two independent ports access any word in the same cycle, even the same one.
// - Address width 16, 17 or 18 bits; words are 72 bits.
// - Control, address and write data are registered on the clock edge.
// - Read data passes an output register before reaching the pins.
// - Each port has a burst counter loaded externally, then advancing.
// - Array write is one internal cycle, independent of write select length.
// - One cycle with a chip enable negated powers the port down.
// - One cycle with both enables asserted is needed before outputs drive.
// - Master reset asserts asynchronously; its release is synchronised to sys_clk over two edges.
// - Each port has its own byte enables.
module dpram_core #(
  parameter int ADDR_W = `DPRAM_ADDR_W_64K
) (
  // Clock and master reset
  input wire logic sys_clk,
  input wire logic master_reset_async,
  // Port A
  input wire dpram_pkg::dpram_req_t req_a,
  output dpram_pkg::dpram_rsp_t rsp_a,
  // Port B
  input wire dpram_pkg::dpram_req_t req_b,
  output dpram_pkg::dpram_rsp_t rsp_b
);
  import dpram_pkg::*;

  // ----------------------------------------
  // Reset
  // ----------------------------------------
  logic rst_n;
  dpram_rst_sync u_rst (
    .sys_clk(sys_clk),
    .rst_n(master_reset_async),
    .rst_sync_n(rst_n)
  );

  // ----------------------------------------
  // Port front ends
  // ----------------------------------------
  logic en_a, wr_a, rd_a, en_b, wr_b, rd_b;
  logic [ADDR_W-1:0] addr_a, addr_b;
  dpram_lanes_t be_a, be_b;
  dpram_word_t wd_a, wd_b;

  dpram_port #(.ADDR_W(ADDR_W)) u_port_a (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .req(req_a),
    .enabled_q(en_a),
    .wr_q(wr_a),
    .rd_q(rd_a),
    .addr_q(addr_a),
    .be_q(be_a),
    .wdata_q(wd_a)
  );

  dpram_port #(.ADDR_W(ADDR_W)) u_port_b (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .req(req_b),
    .enabled_q(en_b),
    .wr_q(wr_b),
    .rd_q(rd_b),
    .addr_q(addr_b),
    .be_q(be_b),
    .wdata_q(wd_b)
  );

  // ----------------------------------------
  // Array
  // ----------------------------------------
  localparam int DEPTH = 1 << ADDR_W;
  dpram_word_t mem [DEPTH];

  function automatic dpram_word_t merge(input dpram_word_t old_w, input dpram_word_t new_w,
                                        input dpram_lanes_t be);
    dpram_word_t res;
    res = old_w;
    for (int i = 0; i < `DPRAM_LANES; i++) begin
      if (be[i]) begin
        res[i*`DPRAM_BYTE_W +: `DPRAM_BYTE_W] = new_w[i*`DPRAM_BYTE_W +: `DPRAM_BYTE_W];
      end
    end
    return res;
  endfunction : merge

  // Each port writes once per registered write cycle; when both hit one
  // word (undefined for the masters) port A's value is kept.
  always_ff @(posedge sys_clk) begin
    if (wr_a) begin
      mem[addr_a] <= merge(mem[addr_a], wd_a, be_a);
    end
    if (wr_b && !(wr_a && addr_a == addr_b)) begin
      mem[addr_b] <= merge(mem[addr_b], wd_b, be_b);
    end
  end

  // ----------------------------------------
  // Read output registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_a <= '0;
      rsp_b <= '0;
    end else begin
      if (rd_a) begin
        rsp_a.rdata <= mem[addr_a];
      end
      if (rd_b) begin
        rsp_b.rdata <= mem[addr_b];
      end
      rsp_a.rvalid <= rd_a;
      rsp_b.rvalid <= rd_b;
      rsp_a.out_en <= en_a && rd_a;
      rsp_b.out_en <= en_b && rd_b;
    end
  end
endmodule : dpram_core

// file: sim/dpram_core_assertions.sv
// Port timing checker for the RAM core
`timescale 1ns/1ps
module dpram_core_assertions #(parameter int ADDR_W = 16) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic master_reset_async,
  // Ports
  input wire dpram_pkg::dpram_req_t req_a,
  input wire dpram_pkg::dpram_rsp_t rsp_a,
  input wire dpram_pkg::dpram_req_t req_b,
  input wire dpram_pkg::dpram_rsp_t rsp_b
);
  import dpram_pkg::*;
  // --
  // Answers
  // --
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!master_reset_async);
  wire en_a = !req_a.chip_enable_active_low && req_a.chip_enable_active_high;
  wire en_b = !req_b.chip_enable_active_low && req_b.chip_enable_active_high;
  // Pins taken at one edge reach the output register one edge later
  a_read_lat: assert property (en_a && !req_a.write_sel |-> ##2 rsp_a.rvalid && rsp_a.out_en)
    else $error("port a read not answered");
  a_read_b: assert property (en_b && !req_b.write_sel |-> ##2 rsp_b.rvalid)
    else $error("port b read not answered");
  a_down_quiet: assert property (!en_a |-> ##2 !rsp_a.out_en && !rsp_a.rvalid)
    else $error("deselected port answered");
  a_write_quiet: assert property (en_a && req_a.write_sel |-> ##2 !rsp_a.rvalid)
    else $error("write gave read answer");
  a_wake_need: assert property ($rose(rsp_a.out_en) |-> $past(en_a, 2))
    else $error("outputs woke without enabled cycle");
  a_data_hold: assert property (!rsp_a.rvalid |-> $stable(rsp_a.rdata))
    else $error("read data moved without read");
  a_oe_valid: assert property (rsp_b.out_en |-> rsp_b.rvalid)
    else $error("drive without read answer");
  a_reset_clear: assert property (disable iff (1'b0) !master_reset_async |-> !rsp_a.rvalid && !rsp_b.out_en)
    else $error("answer during reset");
endmodule : dpram_core_assertions
bind dpram_core dpram_core_assertions #(.ADDR_W(ADDR_W)) u_chk (.sys_clk(sys_clk),
  .master_reset_async(master_reset_async), .req_a(req_a), .rsp_a(rsp_a), .req_b(req_b),
  .rsp_b(rsp_b));

// file: sim/dpram_master.sv
// Bus master model for one RAM port
`timescale 1ns/1ps
module dpram_master (
  // Clock
  input wire logic sys_clk,
  // Port pins
  output dpram_pkg::dpram_req_t req,
  input wire dpram_pkg::dpram_rsp_t rsp
);
  import dpram_pkg::*;
  // --
  // One enabled cycle, then deselect with inverted lines
  // --
  initial begin
    req = '0;
    req.chip_enable_active_low = 1'b1;
  end
  task automatic op(input logic w, input logic [1:0] c, input logic [17:0] a,
      input dpram_lanes_t be, input dpram_word_t d, output dpram_word_t q, output logic v);
    @(posedge sys_clk);
    #1;
    req = '{1'b0, 1'b1, c[0], c[1], w, a, be, d};
    @(posedge sys_clk);
    #1;
    req = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, ~a, ~be, ~d};
    @(posedge sys_clk);
    #1;
    q = rsp.rdata;
    v = rsp.rvalid;
  endtask : op
endmodule : dpram_master

// file: sim/testbench.sv
// Self-checking bench for the RAM core
`timescale 1ns/1ps
module testbench;
  import dpram_pkg::*;
  // --
  // Setup
  // --
  localparam dpram_word_t W0 = 72'h0123456789abcdef12;
  localparam dpram_word_t W1 = 72'hfedcba9876543210ed;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b1;
  dpram_req_t req_a;
  dpram_req_t req_b;
  dpram_rsp_t rsp_a;
  dpram_rsp_t rsp_b;
  dpram_word_t q;
  dpram_word_t r;
  logic v;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 sys_clk = ~sys_clk;
  dpram_core #(.ADDR_W(16)) DUT (.sys_clk(sys_clk), .master_reset_async(rst_n), .req_a(req_a),
    .rsp_a(rsp_a), .req_b(req_b), .rsp_b(rsp_b));
  dpram_master ma (.sys_clk(sys_clk), .req(req_a), .rsp(rsp_a));
  dpram_master mb (.sys_clk(sys_clk), .req(req_b), .rsp(rsp_b));
  task automatic chk(input string nm, input dpram_word_t e, input dpram_word_t g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic t_cross;
    ma.op(1'b1, 2'b01, 18'h5, '1, W0, q, v);
    chk("wr valid", '0, dpram_word_t'(v));
    mb.op(1'b1, 2'b01, 18'h5, 9'h001, W1, q, v);
    ma.op(1'b0, 2'b01, 18'h5, '1, '0, q, v);
    chk("lanes", {W0[71:8], W1[7:0]}, q);
    chk("rd valid", 72'h1, dpram_word_t'(v));
    $display("t_cross end");
  endtask : t_cross
  task automatic t_burst;
    ma.op(1'b1, 2'b01, 18'h20, '1, W1, q, v);
    ma.op(1'b1, 2'b10, 18'h3ffff, '1, W0, q, v);
    fork
      ma.op(1'b0, 2'b01, 18'h21, '1, '0, q, v);
      mb.op(1'b0, 2'b01, 18'h20, '1, '0, r, v);
    join
    chk("burst", W0, q);
    chk("same cycle", W1, r);
    $display("t_burst end");
  endtask : t_burst
  task automatic t_reset;
    #1 rst_n = 1'b0;
    @(posedge sys_clk);
    chk("rst data", '0, rsp_a.rdata);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    mb.op(1'b1, 2'b01, 18'h10005, '1, W1, q, v);
    ma.op(1'b0, 2'b01, 18'h5, '1, '0, q, v);
    chk("alias", W1, q);
    $display("t_reset end");
  endtask : t_reset
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  initial begin
    // A real falling edge so the asynchronous resets act before the first clock
    #1 rst_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    t_cross();
    t_burst();
    t_reset();
    test_done();
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 500) begin
      bad_count++;
      test_done();
    end
  end
endmodule : testbench
